// ==== pkg/fpwm_pkg.sv ====
// Constants and types shared by the flash page window mapper
package fpwm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE    = 8'h0b;
  localparam logic [7:0] IDX_MISC    = 8'h13;
  localparam logic [7:0] IDX_PK_DATA = 8'hfc;
  localparam logic [7:0] IDX_PK_DIR  = 8'hfd;
  localparam logic [7:0] IDX_PAGE    = 8'hff;
  // Values after reset
  localparam logic [2:0] PAGE_RST    = 3'h0;
  localparam logic [4:0] PK_DATA_RST = 5'h00;
  localparam logic [4:0] PK_DIR_RST  = 5'h00;
  localparam logic [1:0] STRETCH_RST = 2'h3;
  localparam logic [3:0] MODE_RST    = 4'h0;
  // Field positions
  localparam int unsigned MISC_TEST_BIT = 7;
  localparam int unsigned MISC_STR_LO   = 2;
  localparam int unsigned MODE_SPEC_BIT = 0;
  localparam int unsigned MODE_EXP_BIT  = 1;
  localparam int unsigned MODE_EMU_BIT  = 2;
  localparam int unsigned MODE_PULL_BIT = 3;
  localparam int unsigned PK_HI_BIT     = 7;
  localparam int unsigned PK_ECS_PIN    = 4;
  // Address windows
  localparam logic [1:0]  WIN_FIXED_LO = 2'b01;
  localparam logic [1:0]  WIN_PROG     = 2'b10;
  localparam logic [1:0]  WIN_FIXED_HI = 2'b11;
  localparam logic [13:0] WIN_REGS     = 14'h003d;
  localparam logic [2:0]  PAGE_FIXED_LO = 3'h6;
  localparam logic [2:0]  PAGE_FIXED_HI = 3'h7;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Chip select sequencer states
  typedef enum logic [2:0] {
    ECS_IDLE   = 3'b001,
    ECS_WAIT   = 3'b010,
    ECS_ACTIVE = 3'b100
  } fpwm_ecs_e;
endpackage

// ==== pkg/fpwm_ecs_if.sv ====
// Signals between the mapper and its chip select sequencer
`timescale 1ns/1ps
`default_nettype none
interface fpwm_ecs_if;
  logic       start;
  logic       ext;
  logic [1:0] stretch;
  logic       e_high;
  logic       ecs_n;
  modport gen  (input start, input ext, input stretch, input e_high, output ecs_n);
  modport user (output start, output ext, output stretch, output e_high, input ecs_n);
endinterface
`default_nettype wire

// ==== verilog/fpwm_ecs_gen.sv ====
// Chip select sequencer timed by the E clock high phase
`timescale 1ns/1ps
`default_nettype none
module fpwm_ecs_gen
  import fpwm_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  fpwm_ecs_if.gen   ecs
);
  fpwm_ecs_e  state_r;
  fpwm_ecs_e  state_nxt;
  logic [1:0] rem_r;
  logic       e_high_d_r;
  logic       e_fall;
  logic       ecs_n_r;

  assign e_fall    = e_high_d_r & ~ecs.e_high;
  assign ecs.ecs_n = ecs_n_r;

  // Next state: wait for E high, then hold through extra E periods
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ECS_IDLE:   if (ecs.start) state_nxt = ecs.e_high ? ECS_ACTIVE : ECS_WAIT;
      ECS_WAIT:   if (ecs.e_high) state_nxt = ECS_ACTIVE;
      ECS_ACTIVE: if (e_fall && rem_r == 2'h0) state_nxt = ECS_IDLE;
      default:    state_nxt = ECS_IDLE;
    endcase
  end

  // State, stretch count and E edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ECS_IDLE;
      rem_r      <= 2'h0;
      e_high_d_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      e_high_d_r <= ecs.e_high;
      if (state_r == ECS_IDLE && ecs.start) begin
        rem_r <= ecs.ext ? ecs.stretch : 2'h0;
      end else if (state_r == ECS_ACTIVE && e_fall && rem_r != 2'h0) begin
        rem_r <= rem_r - 2'h1;
      end
    end
  end

  // Select low only while active
  always_ff @(posedge aclk) begin
    if (!aresetn) ecs_n_r <= 1'b1;
    else          ecs_n_r <= (state_nxt != ECS_ACTIVE);
  end

  AST_ECS_HIGH_PHASE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ECS_WAIT && ecs.e_high) |=> !ecs_n_r)
    else $error("select not asserted at E high");
endmodule
`default_nettype wire

// ==== verilog/fpwm_top.sv ====
// Flash page window mapper with page index, port K and register slave
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fpwm_top
  import fpwm_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [15:0]       cpu_addr,
  input  wire logic              cpu_access,
  input  wire logic              cpu_ext,
  input  wire logic              e_clk_high,
  input  wire logic              call_wr,
  input  wire logic [2:0]        call_wdata,
  output logic [2:0]             call_rdata,
  output logic                   flash_sel,
  output logic [16:0]            flash_addr,
  output logic                   flash_reg_sel,
  output logic [1:0]             flash_reg_array,
  output logic [1:0]             flash_reg_off,
  input  wire logic [4:0]        pk_pin_in,
  output logic [4:0]             pk_pin_out,
  output logic [4:0]             pk_pin_oe,
  output logic [4:0]             pk_pull_en
);
  // Index field needs address bits 9:2
  if (ADDR_W < 10) begin : g_addr_w_chk
    $error("ADDR_W must cover index 0xff times four");
  end

  // Pack five port bits into the byte layout with bits 6:4 zero
  function automatic logic [7:0] pk_pack(input logic [4:0] v);
    pk_pack = {v[4], 3'b000, v[3:0]};
  endfunction

  function automatic logic [4:0] pk_unpack(input logic [7:0] b);
    pk_unpack = {b[PK_HI_BIT], b[3:0]};
  endfunction

  // Register state
  logic [2:0] page_r;
  logic [4:0] pk_data_r;
  logic [4:0] pk_dir_r;
  logic       test_en_r;
  logic [1:0] stretch_r;
  logic [3:0] mode_r;
  logic       special;
  logic       emu_en;
  logic       pk_hidden;

  assign special   = mode_r[MODE_SPEC_BIT];
  assign emu_en    = mode_r[MODE_EMU_BIT];
  assign pk_hidden = mode_r[MODE_EXP_BIT] & emu_en;

  // Bus write channel state
  logic              awready_r;
  logic              wready_r;
  logic              aw_got_r;
  logic              w_got_r;
  logic [7:0]        aw_idx_r;
  logic [7:0]        w_byte_r;
  logic              w_lane_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              do_write;
  logic              wr_hit;

  assign do_write = aw_got_r & w_got_r & ~bvalid_r;

  // Index decode shared by both directions
  function automatic logic idx_mapped(input logic [7:0] idx, input logic hide);
    case (idx)
      IDX_MODE, IDX_MISC, IDX_PAGE: idx_mapped = 1'b1;
      IDX_PK_DATA, IDX_PK_DIR:      idx_mapped = ~hide;
      default:                      idx_mapped = 1'b0;
    endcase
  endfunction

  assign wr_hit = idx_mapped(aw_idx_r, pk_hidden);

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_idx_r  <= 8'h00;
      w_byte_r  <= 8'h00;
      w_lane_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_got_r  <= 1'b1;
        awready_r <= 1'b0;
        aw_idx_r  <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && wready_r) begin
        w_got_r  <= 1'b1;
        wready_r <= 1'b0;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (bvalid_r && s_axi_bready) begin
        aw_got_r  <= 1'b0;
        w_got_r   <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  logic reg_we;
  assign reg_we = do_write & wr_hit & w_lane_r;

  // Page index: instruction path first, then bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_r <= PAGE_RST;
    end else if (call_wr) begin
      page_r <= call_wdata;
    end else if (reg_we && aw_idx_r == IDX_PAGE) begin
      page_r <= w_byte_r[2:0];
    end
  end

  // Port data and direction registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pk_data_r <= PK_DATA_RST;
      pk_dir_r  <= PK_DIR_RST;
    end else if (reg_we) begin
      if (aw_idx_r == IDX_PK_DATA) pk_data_r <= pk_unpack(w_byte_r);
      if (aw_idx_r == IDX_PK_DIR)  pk_dir_r  <= pk_unpack(w_byte_r);
    end
  end

  // Mode and test window, stretch controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r    <= MODE_RST;
      test_en_r <= 1'b0;
      stretch_r <= STRETCH_RST;
    end else begin
      if (reg_we && aw_idx_r == IDX_MODE) mode_r <= w_byte_r[3:0];
      if (reg_we && aw_idx_r == IDX_MISC) begin
        stretch_r <= w_byte_r[MISC_STR_LO +: 2];
        test_en_r <= w_byte_r[MISC_TEST_BIT] & special;
      end else if (!special) begin
        test_en_r <= 1'b0;
      end
    end
  end

  // Read channel
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [7:0]  ar_idx;
  logic [7:0]  rd_byte;
  logic [4:0]  pk_level;

  assign ar_idx   = s_axi_araddr[9:2];
  // Pins driven by the port read back their latch, others the pin
  assign pk_level = (pk_dir_r & pk_data_r) | (~pk_dir_r & pk_pin_in);

  always_comb begin
    case (ar_idx)
      IDX_PAGE:    rd_byte = {5'b00000, page_r};
      IDX_PK_DATA: rd_byte = pk_pack(emu_en ? pk_pin_in : pk_level);
      IDX_PK_DIR:  rd_byte = pk_pack(pk_dir_r);
      IDX_MISC:    rd_byte = {test_en_r, 3'b000, stretch_r, 2'b00};
      IDX_MODE:    rd_byte = {4'h0, mode_r};
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      if (idx_mapped(ar_idx, pk_hidden)) begin
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= RESP_OKAY;
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= RESP_DECERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Window decode of the core address
  logic        test_win;
  logic        in_prog;
  logic        in_fixed;
  logic        in_regs;
  logic [16:0] map_addr;

  assign test_win = special & test_en_r & cpu_addr[15];
  assign in_prog  = test_win | (cpu_addr[15:14] == WIN_PROG);
  assign in_fixed = ~test_win & ((cpu_addr[15:14] == WIN_FIXED_LO) |
                                 (cpu_addr[15:14] == WIN_FIXED_HI));
  assign in_regs  = (cpu_addr[15:2] == WIN_REGS);

  always_comb begin
    if (test_win) begin
      map_addr = {page_r[2:1], cpu_addr[14:0]};
    end else if (cpu_addr[15:14] == WIN_FIXED_LO) begin
      map_addr = {PAGE_FIXED_LO, cpu_addr[13:0]};
    end else if (cpu_addr[15:14] == WIN_FIXED_HI) begin
      map_addr = {PAGE_FIXED_HI, cpu_addr[13:0]};
    end else begin
      map_addr = {page_r, cpu_addr[13:0]};
    end
  end

  // Registered flash selects
  logic        flash_sel_r;
  logic [16:0] flash_addr_r;
  logic        freg_sel_r;
  logic [1:0]  freg_arr_r;
  logic [1:0]  freg_off_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_sel_r  <= 1'b0;
      flash_addr_r <= 17'h00000;
      freg_sel_r   <= 1'b0;
      freg_arr_r   <= 2'h0;
      freg_off_r   <= 2'h0;
    end else begin
      flash_sel_r <= cpu_access & ~cpu_ext & (in_prog | in_fixed);
      freg_sel_r  <= cpu_access & in_regs;
      if (cpu_access) begin
        flash_addr_r <= map_addr;
        freg_arr_r   <= page_r[2:1];
        freg_off_r   <= cpu_addr[1:0];
      end
    end
  end

  // Chip select sequencer
  fpwm_ecs_if ecs_if ();
  assign ecs_if.start   = cpu_access & in_prog;
  assign ecs_if.ext     = cpu_ext;
  assign ecs_if.stretch = stretch_r;
  assign ecs_if.e_high  = e_clk_high;

  fpwm_ecs_gen u_ecs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ecs     (ecs_if.gen)
  );

  // Port K pins: emulation or general purpose
  logic [4:0] pin_out_r;
  logic [4:0] pin_oe_r;
  logic [4:0] pull_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_r <= 5'h00;
      pin_oe_r  <= 5'h00;
      pull_r    <= 5'h00;
    end else begin
      pin_out_r <= pk_data_r;
      pin_oe_r  <= pk_dir_r;
      pull_r    <= ~pk_dir_r & {5{mode_r[MODE_PULL_BIT]}};
      if (emu_en) begin
        pin_out_r[2:0] <= page_r;
        pin_out_r[PK_ECS_PIN] <= ecs_if.ecs_n;
        pin_oe_r[2:0] <= 3'b111;
        pin_oe_r[PK_ECS_PIN] <= 1'b1;
        pull_r[2:0] <= 3'b000;
        pull_r[PK_ECS_PIN] <= 1'b0;
      end
    end
  end

  assign s_axi_awready   = awready_r;
  assign s_axi_wready    = wready_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_arready   = arready_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rdata     = rdata_r;
  assign s_axi_rresp     = rresp_r;
  assign call_rdata      = page_r;
  assign flash_sel       = flash_sel_r;
  assign flash_addr      = flash_addr_r;
  assign flash_reg_sel   = freg_sel_r;
  assign flash_reg_array = freg_arr_r;
  assign flash_reg_off   = freg_off_r;
  assign pk_pin_out      = pin_out_r;
  assign pk_pin_oe       = pin_oe_r;
  assign pk_pull_en      = pull_r;

  // Checks
  AST_PROG_PAGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_access && !cpu_ext && !test_win && cpu_addr[15:14] == WIN_PROG)
      |=> flash_sel_r && flash_addr_r == {$past(page_r), $past(cpu_addr[13:0])})
    else $error("program window maps wrong page");

  AST_FIXED_HI: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_access && !cpu_ext && !test_win && cpu_addr[15:14] == WIN_FIXED_HI)
      |=> flash_addr_r[16:14] == 3'h7)
    else $error("fixed upper window not page 7");

  AST_FIXED_LO: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_access && !cpu_ext && !test_win && cpu_addr[15:14] == WIN_FIXED_LO)
      |=> flash_addr_r[16:14] == 3'h6)
    else $error("fixed lower window not page 6");

  AST_REG_WIN: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_access && cpu_addr[15:2] == WIN_REGS)
      |=> freg_sel_r && freg_arr_r == $past(page_r[2:1]))
    else $error("register window shows wrong array");

  AST_TEST_WIN: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_access && test_win)
      |=> flash_addr_r == {$past(page_r[2:1]), $past(cpu_addr[14:0])})
    else $error("test window address wrong");

  AST_TEST_FORCED: assert property (@(posedge aclk) disable iff (!aresetn)
    !special |=> !test_en_r)
    else $error("test window bit set outside special mode");

  AST_PAGE_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_r && ar_idx == IDX_PAGE)
      |=> rvalid_r && rdata_r == {29'h0, $past(page_r)})
    else $error("index readback wrong");

  AST_CALL_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
    call_wr |=> page_r == $past(call_wdata))
    else $error("call path write lost");

  AST_EMU_MIRROR: assert property (@(posedge aclk) disable iff (!aresetn)
    (emu_en && $stable(page_r)) |=> pin_out_r[2:0] == $past(page_r) && pin_oe_r[2:0] == 3'b111)
    else $error("emulation pins do not mirror index");

  AST_ECS_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    !emu_en |=> pin_out_r[PK_ECS_PIN] == $past(pk_data_r[PK_ECS_PIN]))
    else $error("select pin driven without emulation");

  AST_HIDDEN: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_r && pk_hidden && ar_idx == IDX_PK_DATA)
      |=> rresp_r == RESP_DECERR)
    else $error("port register visible while hidden");

  AST_DIR_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
    !emu_en |=> pin_oe_r == $past(pk_dir_r))
    else $error("direction does not steer enable");
endmodule
`default_nettype wire

// ==== dv/fpwm_pin_model.sv ====
// Board-side model of the port pins: external driver, pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none
module fpwm_pin_model (
  input  wire logic       aclk,
  input  wire logic [4:0] pk_pin_out,
  input  wire logic [4:0] pk_pin_oe,
  input  wire logic [4:0] pk_pull_en,
  input  wire logic [4:0] ext_level,
  input  wire logic [4:0] ext_oe,
  output logic [4:0]      pk_pin_in
);
  logic [4:0] last_r;
  // Pin level from all drivers; a floating pin shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pk_pin_oe[i]) pk_pin_in[i] = pk_pin_out[i];
      else if (ext_oe[i]) pk_pin_in[i] = ext_level[i];
      else if (pk_pull_en[i]) pk_pin_in[i] = 1'b1;
      else pk_pin_in[i] = ~last_r[i];
    end
  end
  // Remembers the last level of each pin
  always_ff @(posedge aclk) last_r <= pk_pin_in;
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the flash page window mapper
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fpwm_pkg::*;
  logic        aclk = 0, aresetn = 0, call_wr = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, flash_reg_array, flash_reg_off, e_cnt = '0;
  logic [15:0] cpu_addr = '0;
  logic        cpu_access = 0, cpu_ext = 0, e_clk_high = 0, flash_sel, flash_reg_sel;
  logic [2:0]  call_wdata = '0, call_rdata;
  logic [16:0] flash_addr;
  logic [4:0]  pk_pin_in, pk_pin_out, pk_pin_oe, pk_pull_en, ext_level = '0, ext_oe = '0;
  int          fails = 0, check_count = 0, n0, n1;
  always #12.5 aclk = ~aclk;
  // E clock phase, four system clocks per period
  always @(posedge aclk) begin
    e_cnt <= e_cnt + 2'h1;
    e_clk_high <= e_cnt[1];
  end
  fpwm_top u_fpwm_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cpu_addr, .cpu_access, .cpu_ext, .e_clk_high, .call_wr, .call_wdata, .call_rdata,
    .flash_sel, .flash_addr, .flash_reg_sel, .flash_reg_array, .flash_reg_off,
    .pk_pin_in, .pk_pin_out, .pk_pin_oe, .pk_pull_en);
  fpwm_pin_model u_fpwm_pin_model (.aclk, .pk_pin_out, .pk_pin_oe, .pk_pull_en, .ext_level,
    .ext_oe, .pk_pin_in);
  // Verdict and end of run
  task automatic finish_test();
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One clock with a bound on the wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60) begin
      fails++;
      finish_test();
    end
  endtask
  // Bus write with expected response
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int   n;
    logic aw, w;
    n = 0;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (aw || w) begin
      tick(n);
      if (aw && s_axi_awready) begin
        s_axi_awvalid <= 0;
        aw = 0;
      end
      if (w && s_axi_wready) begin
        s_axi_wvalid <= 0;
        w = 0;
      end
    end
    aw = 1;
    while (aw) begin
      tick(n);
      if (s_axi_bvalid) begin
        check(s_axi_bresp, er);
        s_axi_bready <= 0;
        aw = 0;
      end
    end
    #1; // Let registered outputs of the write settle
  endtask
  // Bus read with expected data and response
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int   n;
    logic p;
    n = 0;
    p = 1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (p) begin
      tick(n);
      if (s_axi_arready) begin
        s_axi_arvalid <= 0;
        p = 0;
      end
    end
    p = 1;
    while (p) begin
      tick(n);
      if (s_axi_rvalid) begin
        check(s_axi_rdata, {24'h0, d});
        check(s_axi_rresp, er);
        s_axi_rready <= 0;
        p = 0;
      end
    end
  endtask
  // One core access; returns once the answer has settled
  task automatic cpu(input logic [15:0] a, input logic x);
    @(posedge aclk);
    cpu_addr <= a;
    cpu_ext <= x;
    cpu_access <= 1;
    @(posedge aclk);
    cpu_access <= 0;
    #1;
  endtask
  // Program window access, counting cycles with the chip select pin driven low
  task automatic cs(input logic x, output int c);
    int k;
    c = 0;
    k = 0;
    do tick(k); while (e_cnt != 2'h0); // Same E phase on every call
    cpu(16'h8000, x);
    repeat (40) begin
      @(posedge aclk);
      #1;
      if (pk_pin_oe[4] && !pk_pin_out[4]) c++;
    end
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(12'h3fc, 8'h00, RESP_OKAY);
    rd(12'h3f4, 8'h00, RESP_OKAY);
    wr(12'h3fc, 8'hfd, RESP_OKAY);
    rd(12'h3fc, 8'h05, RESP_OKAY);
    rd(12'h100, 8'h00, RESP_DECERR);
    wr(12'h100, 8'h11, RESP_DECERR);
    for (int p = 0; p < 8; p++) begin
      wr(12'h3fc, p[7:0], RESP_OKAY);
      cpu({2'b10, 14'h02a5 + 14'(p)}, 1'b0);
      check(flash_sel, 1'b1);
      check(flash_addr, {p[2:0], 14'h02a5 + 14'(p)});
    end
    wr(12'h3fc, 8'h02, RESP_OKAY);
    cpu(16'h4123, 1'b0);
    check(flash_addr, {3'h6, 14'h0123});
    cpu(16'hc123, 1'b0);
    check(flash_addr, {3'h7, 14'h0123});
    wr(12'h3fc, 8'h05, RESP_OKAY);
    cpu(16'h00f6, 1'b0);
    check({flash_reg_sel, flash_reg_array, flash_reg_off}, {1'b1, 2'h2, 2'h2});
    wr(12'h02c, 8'h01, RESP_OKAY);
    wr(12'h04c, 8'h8c, RESP_OKAY);
    rd(12'h04c, 8'h8c, RESP_OKAY);
    cpu(16'hc123, 1'b0);
    check(flash_addr, {2'h2, 15'h4123});
    wr(12'h02c, 8'h00, RESP_OKAY);
    rd(12'h04c, 8'h0c, RESP_OKAY);
    wr(12'h04c, 8'h8c, RESP_OKAY);
    rd(12'h04c, 8'h0c, RESP_OKAY);
    @(posedge aclk);
    call_wr <= 1;
    call_wdata <= 3'h3;
    @(posedge aclk);
    call_wr <= 0;
    @(posedge aclk);
    #1;
    check(call_rdata, 3'h3);
    rd(12'h3fc, 8'h03, RESP_OKAY);
    wr(12'h3f4, 8'hff, RESP_OKAY);
    rd(12'h3f4, 8'h8f, RESP_OKAY);
    wr(12'h3f0, 8'hfa, RESP_OKAY);
    check(pk_pin_oe, 5'h1f);
    check(pk_pin_out, 5'h1a);
    rd(12'h3f0, 8'h8a, RESP_OKAY);
    ext_oe <= 5'h01;
    wr(12'h3f4, 8'h00, RESP_OKAY);
    wr(12'h02c, 8'h08, RESP_OKAY);
    check(pk_pull_en, 5'h1f);
    rd(12'h3f0, 8'h8e, RESP_OKAY);
    wr(12'h02c, 8'h04, RESP_OKAY);
    wr(12'h3fc, 8'h05, RESP_OKAY);
    check(pk_pin_oe, 5'h17);
    check(pk_pin_out[2:0], 3'h5);
    wr(12'h3f0, 8'h00, RESP_OKAY);
    check(pk_pin_out[2:0], 3'h5);
    wr(12'h3fc, 8'h02, RESP_OKAY);
    check(pk_pin_out[2:0], 3'h2);
    wr(12'h04c, 8'h0c, RESP_OKAY);
    cs(1'b0, n0);
    cs(1'b1, n1);
    check(n0 > 0, 1'b1);
    check(n1 - n0, 12);
    wr(12'h04c, 8'h04, RESP_OKAY);
    cs(1'b1, n1);
    check(n1 - n0, 4);
    wr(12'h02c, 8'h06, RESP_OKAY);
    rd(12'h3f0, 8'h00, RESP_DECERR);
    wr(12'h3f4, 8'hff, RESP_DECERR);
    rd(12'h3fc, 8'h02, RESP_OKAY);
    wr(12'h02c, 8'h00, RESP_OKAY);
    wr(12'h3f4, 8'h80, RESP_OKAY);
    wr(12'h3f0, 8'h80, RESP_OKAY);
    cs(1'b0, n0);
    check(n0, 0);
    finish_test();
  end
endmodule
`default_nettype wire
